// File: shared/ppw_pkg.sv
package ppw_pkg;

   // Geometry
   localparam int PPW_QUEUES = 4;
   localparam int PPW_ADDR_W = 12;
   localparam int PPW_MON_W  = 24;
   localparam int PPW_THR_W  = 11;

   // Register byte offsets inside the APB space shared by all ports
   localparam logic [11:0] PPW_OFF_POINTER = 12'h004;
   localparam logic [11:0] PPW_OFF_CONTROL = 12'h00c;
   localparam logic [11:0] PPW_OFF_RATE    = 12'h020;
   localparam logic [11:0] PPW_OFF_BURST   = 12'h024;
   localparam logic [11:0] PPW_OFF_MEM_THR = 12'h030;
   localparam logic [11:0] PPW_OFF_MEM_SCL = 12'h034;
   localparam logic [11:0] PPW_OFF_MONITOR = 12'h048;

   // Control register fields
   localparam int CTL_W          = 12;
   localparam int CTL_DROP_COLOR = 11;
   localparam int CTL_DROP_ALL   = 10;
   localparam int CTL_PTYPE_HI   = 9;
   localparam int CTL_PTYPE_LO   = 8;
   localparam int CTL_PORT_BASED = 7;
   localparam int CTL_NONIP_HI   = 6;
   localparam int CTL_NONIP_LO   = 5;
   localparam int CTL_MARK       = 4;
   localparam int CTL_REMAP      = 3;
   localparam int CTL_SRP        = 2;
   localparam int CTL_MODE       = 1;
   localparam int CTL_EN         = 0;

   // Pointer, half-word and threshold fields
   localparam int PTR_PORT_LO  = 16;
   localparam int PTR_QUEUE_LO = 0;
   localparam int HALF_HI_LO   = 16;
   localparam int THR_MAX_LO   = 16;
   localparam int THR_MIN_LO   = 0;

   // Reset values
   localparam logic [15:0]     RST_COMMITTED_RATE  = 16'h1000;
   localparam logic [15:0]     RST_PEAK_RATE       = 16'h2000;
   localparam logic [15:0]     RST_COMMITTED_BURST = 16'h1000;
   localparam logic [15:0]     RST_PEAK_BURST      = 16'h3000;
   localparam logic [10:0]     RST_MEM_MAX         = 11'h400;
   localparam logic [10:0]     RST_MEM_MIN         = 11'h080;
   localparam logic [10:0]     RST_MEM_SCALE       = 11'h020;
   localparam logic [1:0]      RST_NON_IP_COLOR    = 2'h1;
   localparam logic [CTL_W-1:0] RST_CONTROL        = 12'h020;
   localparam logic [31:0]     PPW_ZERO_WORD       = 32'h0000_0000;

   typedef enum logic [1:0] {
      PPW_PT_DROPPED = 2'h0,
      PPW_PT_GREEN   = 2'h1,
      PPW_PT_YELLOW  = 2'h2,
      PPW_PT_RED     = 2'h3
   } ppw_pkt_type_t;

   typedef logic [2:0] ppw_port_t;
   typedef logic [1:0] ppw_queue_t;
   typedef logic [4:0] ppw_slot_t;

   function automatic ppw_slot_t ppw_slot(input ppw_port_t p, input ppw_queue_t q);
      return {p, q};
   endfunction

   function automatic logic ppw_port_ok(input ppw_port_t p, input int np);
      return (int'(p) < np);
   endfunction

endpackage

// File: shared/ppw_cfg_if.sv
`timescale 1ns/1ps
interface ppw_cfg_if;
   import ppw_pkg::*;
   logic        wr_rate;
   logic        wr_burst;
   logic [31:0] wdata;
   ppw_port_t   sw_port;
   ppw_queue_t  sw_queue;
   logic [31:0] sw_rate;
   logic [31:0] sw_burst;
   ppw_port_t   lk_port;
   ppw_queue_t  lk_queue;
   logic [31:0] lk_rate;
   logic [31:0] lk_burst;

   modport ctrl (
      output wr_rate, wr_burst, wdata, sw_port, sw_queue, lk_port, lk_queue,
      input  sw_rate, sw_burst, lk_rate, lk_burst
   );
   modport store (
      input  wr_rate, wr_burst, wdata, sw_port, sw_queue, lk_port, lk_queue,
      output sw_rate, sw_burst, lk_rate, lk_burst
   );
endinterface

// File: design/ppw_rate_store.sv
`timescale 1ns/1ps
module ppw_rate_store
   import ppw_pkg::*;
#(
   parameter int NUM_PORTS = 7
) (
   // Clock and reset
   input wire logic  pclk,
   input wire logic  presetn,
   // Configuration carrier
   ppw_cfg_if.store  cfg
);
   localparam int NS = NUM_PORTS * PPW_QUEUES;

   logic [31:0] rate_q  [NS];
   logic [31:0] burst_q [NS];

   wire ppw_slot_t sw_slot = ppw_slot(cfg.sw_port, cfg.sw_queue);
   wire ppw_slot_t lk_slot = ppw_slot(cfg.lk_port, cfg.lk_queue);
   wire logic      sw_ok   = ppw_port_ok(cfg.sw_port, NUM_PORTS);
   wire logic      lk_ok   = ppw_port_ok(cfg.lk_port, NUM_PORTS);

   // Index beyond the last port is a hole: writes dropped, reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NS; i++) begin
            rate_q[i]  <= {RST_COMMITTED_RATE, RST_PEAK_RATE};
            burst_q[i] <= {RST_COMMITTED_BURST, RST_PEAK_BURST};
         end
      end else begin
         if (cfg.wr_rate && sw_ok) begin
            rate_q[sw_slot] <= cfg.wdata;
         end
         if (cfg.wr_burst && sw_ok) begin
            burst_q[sw_slot] <= cfg.wdata;
         end
      end
   end

   assign cfg.sw_rate  = sw_ok ? rate_q[sw_slot]  : PPW_ZERO_WORD;
   assign cfg.sw_burst = sw_ok ? burst_q[sw_slot] : PPW_ZERO_WORD;
   assign cfg.lk_rate  = lk_ok ? rate_q[lk_slot]  : PPW_ZERO_WORD;
   assign cfg.lk_burst = lk_ok ? burst_q[lk_slot] : PPW_ZERO_WORD;

   a_rate_write_lands: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cfg.wr_rate && sw_ok) |=> rate_q[$past(sw_slot)] == $past(cfg.wdata))
      else $error("Rate write did not land in the indexed slot");

   a_burst_write_lands: assert property (
      @(posedge pclk) disable iff (!presetn)
      (cfg.wr_burst && sw_ok) |=> burst_q[$past(sw_slot)] == $past(cfg.wdata))
      else $error("Burst write did not land in the indexed slot");

   a_hole_reads_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      !sw_ok |-> (cfg.sw_rate == PPW_ZERO_WORD && cfg.sw_burst == PPW_ZERO_WORD))
      else $error("Out of range port index returned data");

endmodule

// File: design/ppw_top.sv
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ppw_top
   import ppw_pkg::*;
#(
   parameter int NUM_PORTS = 7,
   parameter int CNT_W     = PPW_MON_W
) (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic [PPW_ADDR_W-1:0] paddr,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Packet events from the forwarding path
   input  wire logic                 ev_valid,
   input  wire ppw_port_t            ev_port,
   input  wire ppw_queue_t           ev_queue,
   input  wire logic [1:0]           ev_color,
   input  wire logic                 ev_dropped,
   // Packet memory fill level
   input  wire logic [PPW_THR_W-1:0] pm_level,
   // Rate lookup from the policer
   input  wire ppw_port_t            lk_port,
   input  wire ppw_queue_t           lk_queue,
   output logic      [15:0]          committed_rate_q,
   output logic      [15:0]          peak_rate_q,
   output logic      [15:0]          committed_burst_q,
   output logic      [15:0]          peak_burst_q,
   // Policing and WRED controls
   output logic                      police_on_q,
   output logic                      port_based_q,
   output logic                      color_blind_q,
   output logic                      dscp_mark_q,
   output logic                      dscp_remap_q,
   output logic                      srp_drop_ok_q,
   output logic      [1:0]           non_ip_frame_color_q,
   output logic                      wred_force_drop_q,
   output logic [PPW_THR_W-1:0]      memory_drop_probability_scale_q,
   output logic [PPW_THR_W-1:0]      wred_max_q,
   output logic [PPW_THR_W-1:0]      wred_min_q
);
   localparam int NS = NUM_PORTS * PPW_QUEUES;

   ppw_cfg_if cfg ();

   // Register state
   logic [CTL_W-1:0]     ctl_q;
   ppw_port_t            ptr_port_q;
   ppw_queue_t           ptr_queue_q;
   logic [PPW_THR_W-1:0] mem_max_q;
   logic [PPW_THR_W-1:0] mem_min_q;
   logic [PPW_THR_W-1:0] mem_scale_q;
   logic [CNT_W-1:0]     cnt_q [NS][4];
   logic                 pready_q;
   logic [31:0]          prdata_q;
   logic                 pslverr_q;

   // Control fields
   wire logic       ctl_en         = ctl_q[CTL_EN];
   wire logic       ctl_mode       = ctl_q[CTL_MODE];
   wire logic       ctl_srp        = ctl_q[CTL_SRP];
   wire logic       ctl_remap      = ctl_q[CTL_REMAP];
   wire logic       ctl_mark       = ctl_q[CTL_MARK];
   wire logic [1:0] ctl_nonip      = ctl_q[CTL_NONIP_HI:CTL_NONIP_LO];
   wire logic       ctl_port_based = ctl_q[CTL_PORT_BASED];
   wire logic [1:0] ctl_ptype      = ctl_q[CTL_PTYPE_HI:CTL_PTYPE_LO];
   wire logic       ctl_drop_all   = ctl_q[CTL_DROP_ALL];
   wire logic       ctl_drop_color = ctl_q[CTL_DROP_COLOR];

   // Address decode
   wire logic hit_ptr   = (paddr == PPW_OFF_POINTER);
   wire logic hit_ctl   = (paddr == PPW_OFF_CONTROL);
   wire logic hit_rate  = (paddr == PPW_OFF_RATE);
   wire logic hit_burst = (paddr == PPW_OFF_BURST);
   wire logic hit_thr   = (paddr == PPW_OFF_MEM_THR);
   wire logic hit_scl   = (paddr == PPW_OFF_MEM_SCL);
   wire logic hit_mon   = (paddr == PPW_OFF_MONITOR);
   wire logic hit_any   = hit_ptr | hit_ctl | hit_rate | hit_burst | hit_thr | hit_scl | hit_mon;

   // One wait state so read data comes from a flop
   wire logic acc_phase = psel & penable;
   wire logic capture   = acc_phase & ~pready_q;
   wire logic wr_fire   = acc_phase & pready_q & pwrite & hit_any;

   wire logic wr_ptr = wr_fire & hit_ptr;
   wire logic wr_ctl = wr_fire & hit_ctl;
   wire logic wr_thr = wr_fire & hit_thr;
   wire logic wr_scl = wr_fire & hit_scl;

   // Monitor readback for the indexed connection
   wire ppw_slot_t  sw_slot  = ppw_slot(ptr_port_q, ptr_queue_q);
   wire logic       sw_ok    = ppw_port_ok(ptr_port_q, NUM_PORTS);
   wire logic [CNT_W-1:0] mon_sel = sw_ok ? cnt_q[sw_slot][ctl_ptype] : '0;

   // Read word assembly; reserved bits stay zero
   wire logic [31:0] rd_ptr = {13'h0000, ptr_port_q, 14'h0000, ptr_queue_q};
   wire logic [31:0] rd_ctl = {20'h0_0000, ctl_q};
   wire logic [31:0] rd_thr = {5'h00, mem_max_q, 5'h00, mem_min_q};
   wire logic [31:0] rd_scl = {5'h00, mem_scale_q, 16'h0000};
   wire logic [31:0] rd_mon = {{(32 - CNT_W){1'b0}}, mon_sel};
   wire logic [31:0] rd_word =
      hit_ptr   ? rd_ptr       :
      hit_ctl   ? rd_ctl       :
      hit_rate  ? cfg.sw_rate  :
      hit_burst ? cfg.sw_burst :
      hit_thr   ? rd_thr       :
      hit_scl   ? rd_scl       :
      hit_mon   ? rd_mon       : PPW_ZERO_WORD;

   // Carrier to the indexed rate store
   assign cfg.wr_rate  = wr_fire & hit_rate;
   assign cfg.wr_burst = wr_fire & hit_burst;
   assign cfg.wdata    = pwdata;
   assign cfg.sw_port  = ptr_port_q;
   assign cfg.sw_queue = ptr_queue_q;
   assign cfg.lk_port  = ctl_port_based ? lk_port : 3'h0;
   assign cfg.lk_queue = lk_queue;

   ppw_rate_store #(
      .NUM_PORTS (NUM_PORTS)
   ) u_store (
      .pclk    (pclk),
      .presetn (presetn),
      .cfg     (cfg.store)
   );

   // APB response
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= PPW_ZERO_WORD;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= capture;
         if (capture) begin
            prdata_q  <= pwrite ? PPW_ZERO_WORD : rd_word;
            pslverr_q <= ~hit_any;
         end
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // Software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q       <= RST_CONTROL;
         ptr_port_q  <= 3'h0;
         ptr_queue_q <= 2'h0;
         mem_max_q   <= RST_MEM_MAX;
         mem_min_q   <= RST_MEM_MIN;
         mem_scale_q <= RST_MEM_SCALE;
      end else begin
         if (wr_ctl) begin
            ctl_q <= pwdata[CTL_W-1:0];
         end
         if (wr_ptr) begin
            ptr_port_q  <= pwdata[PTR_PORT_LO +: 3];
            ptr_queue_q <= pwdata[PTR_QUEUE_LO +: 2];
         end
         if (wr_thr) begin
            mem_max_q <= pwdata[THR_MAX_LO +: PPW_THR_W];
            mem_min_q <= pwdata[THR_MIN_LO +: PPW_THR_W];
         end
         if (wr_scl) begin
            mem_scale_q <= pwdata[HALF_HI_LO +: PPW_THR_W];
         end
      end
   end

   // Counter increments; colour 00 on an event carries no colour
   wire ppw_slot_t  ev_slot = ppw_slot(ev_port, ev_queue);
   wire logic       ev_hit  = ev_valid & ppw_port_ok(ev_port, NUM_PORTS);
   wire logic [3:0] cnt_inc;
   assign cnt_inc[PPW_PT_DROPPED] = ev_hit & ev_dropped;
   for (genvar t = 1; t < 4; t++) begin : g_inc
      assign cnt_inc[t] = ev_hit & (ev_color == 2'(t)) & (~ctl_drop_color | ev_dropped);
   end

   // Counters wrap; no saturation since software reads deltas
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < NS; s++) begin
            for (int t = 0; t < 4; t++) begin
               cnt_q[s][t] <= '0;
            end
         end
      end else begin
         for (int t = 0; t < 4; t++) begin
            if (cnt_inc[t]) begin
               cnt_q[ev_slot][t] <= cnt_q[ev_slot][t] + 1'b1;
            end
         end
      end
   end

   // Registered controls toward the datapath
   wire logic pm_over = pm_level > mem_max_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         police_on_q                     <= 1'b0;
         port_based_q                    <= 1'b0;
         color_blind_q                   <= 1'b0;
         dscp_mark_q                     <= 1'b0;
         dscp_remap_q                    <= 1'b0;
         srp_drop_ok_q                   <= 1'b0;
         non_ip_frame_color_q            <= RST_NON_IP_COLOR;
         wred_force_drop_q               <= 1'b0;
         memory_drop_probability_scale_q <= '0;
         wred_max_q                      <= RST_MEM_MAX;
         wred_min_q                      <= RST_MEM_MIN;
      end else begin
         police_on_q                     <= ctl_en;
         port_based_q                    <= ctl_port_based;
         color_blind_q                   <= ctl_en & ctl_mode;
         dscp_mark_q                     <= ctl_en & ctl_mark;
         dscp_remap_q                    <= ctl_en & ~ctl_mode & ctl_remap;
         srp_drop_ok_q                   <= ctl_en & ctl_srp;
         non_ip_frame_color_q            <= ctl_nonip;
         wred_force_drop_q               <= ctl_en & ctl_drop_all & pm_over;
         memory_drop_probability_scale_q <= (ctl_en & ~ctl_drop_all) ? mem_scale_q : '0;
         wred_max_q                      <= mem_max_q;
         wred_min_q                      <= mem_min_q;
      end
   end

   // Lookup result, one cycle behind the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         committed_rate_q  <= RST_COMMITTED_RATE;
         peak_rate_q       <= RST_PEAK_RATE;
         committed_burst_q <= RST_COMMITTED_BURST;
         peak_burst_q      <= RST_PEAK_BURST;
      end else begin
         committed_rate_q  <= cfg.lk_rate[HALF_HI_LO +: 16];
         peak_rate_q       <= cfg.lk_rate[15:0];
         committed_burst_q <= cfg.lk_burst[HALF_HI_LO +: 16];
         peak_burst_q      <= cfg.lk_burst[15:0];
      end
   end

   wire logic [CNT_W-1:0] ev_cnt = cnt_q[ev_slot][ev_color];

   a_apb_one_wait: assert property (
      @(posedge pclk) disable iff (!presetn)
      capture |=> pready_q ##1 !pready_q)
      else $error("APB answer did not follow one wait state");

   a_drop_all_force: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ctl_en && ctl_drop_all && pm_level > mem_max_q) |=> wred_force_drop_q)
      else $error("Drop-all did not force a drop above maximum threshold");

   a_scale_gated: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ctl_drop_all || !ctl_en) |=> memory_drop_probability_scale_q == '0)
      else $error("Probability scale passed while drop-all set");

   a_enable_off_all: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_ctl && !pwdata[CTL_EN]) |=> ##1 (!police_on_q && !color_blind_q && !srp_drop_ok_q && !dscp_mark_q))
      else $error("Policing output stayed on after disable");

   a_remap_aware_only: assert property (
      @(posedge pclk) disable iff (!presetn)
      dscp_remap_q |-> (!color_blind_q && police_on_q))
      else $error("DSCP remap active outside colour-aware mode");

   a_shared_rates: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!ctl_port_based && ppw_port_ok(lk_port, NUM_PORTS)) |-> cfg.lk_port == 3'h0)
      else $error("Per-queue policing did not use port zero");

   a_monitor_pick: assert property (
      @(posedge pclk) disable iff (!presetn)
      (capture && !pwrite && hit_mon) |=> prdata_q[CNT_W-1:0] == $past(mon_sel))
      else $error("Monitor read returned the wrong count");

   a_dropped_only: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ev_hit && ctl_drop_color && !ev_dropped && ev_color != 2'h0)
      |=> cnt_q[$past(ev_slot)][$past(ev_color)] == $past(ev_cnt))
      else $error("Colour count moved on a passed packet");

   a_count_all: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ev_hit && !ctl_drop_color && ev_color != 2'h0)
      |=> cnt_q[$past(ev_slot)][$past(ev_color)] == $past(ev_cnt) + 1'b1)
      else $error("Colour count missed a packet");

   a_thr_reserved: assert property (
      @(posedge pclk) disable iff (!presetn)
      (capture && hit_thr) |=> (prdata_q[31:27] == 5'h00 && prdata_q[15:11] == 5'h00))
      else $error("Threshold reserved bits read nonzero");

   a_mark_follows: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ctl_en && ctl_mark) |=> dscp_mark_q)
      else $error("Colour marking not enabled");

   a_srp_gated: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!ctl_en || !ctl_srp) |=> !srp_drop_ok_q)
      else $error("Stream reservation drop allowed while forbidden");

   a_blind_mode: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ctl_en && ctl_mode) |=> color_blind_q)
      else $error("Colour blind mode not selected");

   a_port_lookup: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctl_port_based |-> cfg.lk_port == lk_port)
      else $error("Port based policing ignored the lookup port");

   a_non_ip_color: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ctl_nonip != non_ip_frame_color_q) |=> non_ip_frame_color_q == $past(ctl_nonip))
      else $error("Non-IP frame colour not passed on");

endmodule

// File: dv/ppw_top_tb_top.sv
`timescale 1ns/1ps
module ppw_top_tb_top;
   import ppw_pkg::*;
   logic                  pclk = 1'b0;
   logic                  presetn = 1'b0;
   logic [PPW_ADDR_W-1:0] paddr = '0;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   logic [31:0]           pwdata = '0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  ev_valid = 1'b0;
   ppw_port_t             ev_port = 3'h1;
   ppw_queue_t            ev_queue = 2'h2;
   logic [1:0]            ev_color = '0;
   logic                  ev_dropped = 1'b0;
   logic [PPW_THR_W-1:0]  pm_level = '0;
   ppw_port_t             lk_port = '0;
   ppw_queue_t            lk_queue = '0;
   logic [15:0]           committed_rate_q, peak_rate_q, committed_burst_q, peak_burst_q;
   logic                  police_on_q, port_based_q, color_blind_q, dscp_mark_q, dscp_remap_q, srp_drop_ok_q;
   logic                  wred_force_drop_q;
   logic [1:0]            non_ip_frame_color_q;
   logic [PPW_THR_W-1:0]  memory_drop_probability_scale_q, wred_max_q, wred_min_q;
   logic [31:0]           rd;
   logic                  er;
   int                    error_cnt = 0;
   int                    checks_done = 0;
   logic [11:0]           r_off [6] = '{PPW_OFF_CONTROL, PPW_OFF_RATE, PPW_OFF_BURST, PPW_OFF_MEM_THR,
                                        PPW_OFF_MEM_SCL, PPW_OFF_POINTER};
   logic [31:0]           r_rst [6] = '{32'h0000_0020, 32'h1000_2000, 32'h1000_3000, 32'h0400_0080,
                                        32'h0020_0000, 32'h0000_0000};
   logic [11:0]           c_wr [3] = '{12'h05f, 12'h089, 12'h09e};
   logic [5:0]            c_ex [3] = '{6'h2d, 6'h32, 6'h10};
   int                    m1 [4] = '{2, 1, 1, 2};
   int                    m2 [4] = '{3, 2, 1, 2};

   ppw_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .ev_valid, .ev_port, .ev_queue, .ev_color, .ev_dropped, .pm_level, .lk_port, .lk_queue,
      .committed_rate_q, .peak_rate_q, .committed_burst_q, .peak_burst_q, .police_on_q, .port_based_q,
      .color_blind_q, .dscp_mark_q, .dscp_remap_q, .srp_drop_ok_q, .non_ip_frame_color_q,
      .wred_force_drop_q, .memory_drop_probability_scale_q, .wred_max_q, .wred_min_q);

   always #2 pclk = ~pclk;

   wire [5:0] ctl_view = {police_on_q, port_based_q, color_blind_q, dscp_mark_q, dscp_remap_q, srp_drop_ok_q};

   task automatic end_sim();
      if (error_cnt == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         error_cnt++;
      end
   endtask

   // Caller enters just after a rising edge; one idle edge follows so strobes never toggle twice
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) begin
         error_cnt++;
         end_sim();
      end
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   function automatic logic [31:0] rv(input int p, input int q);
      return 32'h0101_0a0a + 32'((p * 4 + q) * 32'h0001_0001);
   endfunction

   task automatic evs(input logic [11:0] list, input int n);
      for (int i = 0; i < n; i++) begin
         {ev_color, ev_dropped} <= list[3*i +: 3];
         ev_valid <= 1'b1;
         @(posedge pclk);
      end
      ev_valid <= 1'b0;
      tick(2);
   endtask

   initial begin
      tick(6);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({committed_rate_q, peak_rate_q}, {RST_COMMITTED_RATE, RST_PEAK_RATE});
      chk({committed_burst_q, peak_burst_q}, {RST_COMMITTED_BURST, RST_PEAK_BURST});
      chk({5'h00, wred_max_q, 5'h00, wred_min_q}, 32'h0400_0080);
      chk(32'(ctl_view), 32'h0000_0000);
      chk(32'(non_ip_frame_color_q), 32'h0000_0001);
      for (int i = 0; i < 6; i++) begin
         xfer(1'b0, r_off[i], '0);
         chk(rd, r_rst[i]);
      end
      xfer(1'b0, 12'h0fc, '0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      xfer(1'b1, PPW_OFF_MEM_THR, 32'hffff_ffff);
      xfer(1'b0, PPW_OFF_MEM_THR, '0);
      chk(rd, 32'h07ff_07ff);
      for (int p = 0; p < 8; p++) begin
         for (int q = 0; q < 4; q++) begin
            xfer(1'b1, PPW_OFF_POINTER, {13'h0, 3'(p), 14'h0, 2'(q)});
            xfer(1'b1, PPW_OFF_RATE, rv(p, q));
            xfer(1'b1, PPW_OFF_BURST, ~rv(p, q));
         end
      end
      for (int p = 0; p < 8; p++) begin
         for (int q = 0; q < 4; q++) begin
            xfer(1'b1, PPW_OFF_POINTER, {13'h0, 3'(p), 14'h0, 2'(q)});
            xfer(1'b0, PPW_OFF_RATE, '0);
            chk(rd, (p < 7) ? rv(p, q) : 32'h0);
            xfer(1'b0, PPW_OFF_BURST, '0);
            chk(rd, (p < 7) ? ~rv(p, q) : 32'h0);
         end
      end
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, PPW_OFF_CONTROL, {20'h0, c_wr[i]});
         tick(1);
         chk(32'(ctl_view), 32'(c_ex[i]));
      end
      chk(32'(non_ip_frame_color_q), 32'h0000_0000);
      xfer(1'b1, PPW_OFF_CONTROL, 32'h0000_0081);
      lk_port <= 3'h3; lk_queue <= 2'h2;
      tick(2);
      chk({committed_rate_q, peak_rate_q}, rv(3, 2));
      chk({committed_burst_q, peak_burst_q}, ~rv(3, 2));
      xfer(1'b1, PPW_OFF_CONTROL, 32'h0000_0001);
      tick(1);
      chk({committed_rate_q, peak_rate_q}, rv(0, 2));
      xfer(1'b1, PPW_OFF_MEM_THR, 32'h0100_0080);
      xfer(1'b1, PPW_OFF_CONTROL, 32'h0000_0401);
      pm_level <= 11'h101;
      tick(2);
      chk({wred_force_drop_q, 20'h0, memory_drop_probability_scale_q}, 32'h8000_0000);
      chk({5'h00, wred_max_q, 5'h00, wred_min_q}, 32'h0100_0080);
      pm_level <= 11'h100;
      tick(2);
      chk(32'(wred_force_drop_q), 32'h0);
      pm_level <= 11'h101;
      xfer(1'b1, PPW_OFF_CONTROL, 32'h0000_0001);
      tick(1);
      chk({wred_force_drop_q, 20'h0, memory_drop_probability_scale_q}, 32'h0000_0020);
      // Monitor indexed at port 1 queue 2, which is where the events go
      xfer(1'b1, PPW_OFF_POINTER, 32'h0001_0002);
      evs(12'hfaa, 4);
      for (int t = 0; t < 4; t++) begin
         xfer(1'b1, PPW_OFF_CONTROL, 32'(t) << 8);
         xfer(1'b0, PPW_OFF_MONITOR, '0);
         chk(rd, 32'(m1[t]));
      end
      // Dropped-colour mode must be on while the second batch arrives
      xfer(1'b1, PPW_OFF_CONTROL, 32'h0000_0800);
      evs(12'h11a, 3);
      for (int t = 0; t < 4; t++) begin
         xfer(1'b1, PPW_OFF_CONTROL, 32'h0000_0800 | (32'(t) << 8));
         xfer(1'b0, PPW_OFF_MONITOR, '0);
         chk(rd, 32'(m2[t]));
      end
      end_sim();
   end
endmodule
